/* File: core/sensor_link_master.sv */
// host-side master that drives the sensor serial port through its pins
// assumes cmd_valid_i is from sys_clk_i logic and miso_i is asynchronous
//
// Summary of operation
// (R01) only this master starts transfers
// (R02) sensor ignores port in sleep or reset
// (R03) select high: sensor ignores, output floats; the port model toggles miso instead
// (R04) select falls before any clocking
// (R05) select rise aborts whole transaction
// (R06) gaps still kept after abort
// (R07) select framed per transaction, idle high
// (R08) select raised after each burst
// (R09) write: address with top bit one, data
// (R10) mosi sampled on rising serial clock
// (R11) read: address top bit zero, data back
// (R12) sensor drives data on falling edge
// (R13) sensor holds data until next fall
// (R14) 50 us between write data ends
// (R15) 50 us write end to read address
// (R16) 250 ns after read before next fall
// (R17) clock paused after read address byte
// (R18) pull-ups allow open-drain master drive
// (R19) 50 us address-to-data for reads
// (R20) 75 us for motion registers
// (R21) select high 4 us ends burst
// (R22) unassigned read returns zero
// (R23) most significant bit first
`timescale 1ns/1ps
module sensor_link_master
  import sensor_link_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire cmd_t cmd_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  input wire logic miso_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  output logic mosi_o,
  output logic mosi_oe_n_o,
  output logic select_bar_o,
  output logic select_bar_oe_n_o,
  input wire logic sleep_request_low_abort_i,
  output logic sleep_request_low_o
);

  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_SEL = 7'b0000010,
    S_ADDR = 7'b0000100,
    S_WAIT = 7'b0001000,
    S_DATA = 7'b0010000,
    S_DESEL = 7'b0100000,
    S_GAP = 7'b1000000
  } state_t;

  state_t state;
  cmd_t cmd;
  pins_t pins;
  logic [14:0] timer;
  logic [3:0] bit_cnt;
  logic phase;
  logic [7:0] shift;
  logic [2:0] miso_sync;
  logic miso_val;
  logic last_write;

  function automatic logic [14:0] cyc(input int unsigned n);
    return n[14:0];
  endfunction

  // wait after a read address byte depends on the register class
  function automatic logic [14:0] rad_wait(input logic [6:0] a);
    return (a == MOTION_ADDR || a == MOTION_BURST_ADDR) ?
      cyc(RAD_MOT_CYC) : cyc(RAD_CYC); // [R19] [R20]
  endfunction

  assign cmd_ready_o = (state == S_IDLE);
  // pins are driven push-pull; enables low means driving  [R18]
  assign sclk_o = pins.sclk;
  assign mosi_o = pins.mosi;
  assign select_bar_o = pins.select_bar;
  assign sclk_oe_n_o = 1'b0;
  assign mosi_oe_n_o = 1'b0;
  assign select_bar_oe_n_o = 1'b0;
  // sensor is kept awake; port only used while awake  [R02]
  assign sleep_request_low_o = 1'b1;

  //////////////////////////////////////////////////////////////////////////
  // miso synchroniser; value taken when second and third stages agree

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      miso_sync <= 3'h0;
    end else begin
      miso_sync <= {miso_sync[1:0], miso_i};
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      miso_val <= 1'b0;
    end else if (miso_sync[1] == miso_sync[2]) begin
      miso_val <= miso_sync[2];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transaction sequencer

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= S_IDLE;
      cmd <= '0;
      pins <= '{sclk: 1'b1, mosi: 1'b1, select_bar: 1'b1};
      timer <= '0;
      bit_cnt <= '0;
      phase <= 1'b0;
      shift <= RESET_DATA;
      rd_data_o <= RESET_DATA;
      rd_valid_o <= 1'b0;
      last_write <= 1'b0;
    end else begin
      rd_valid_o <= 1'b0;
      if (timer != '0) begin
        timer <= timer - 15'h0001;
      end
      unique case (state)
        S_IDLE: begin
          pins.select_bar <= 1'b1; // [R03] [R07]
          pins.sclk <= 1'b1;
          if (cmd_valid_i) begin // [R01]
            cmd <= cmd_i;
            // address byte, direction flag leading  [R09] [R11] [R23]
            shift <= {cmd_i.write, cmd_i.addr};
            pins.select_bar <= 1'b0; // [R04]
            timer <= cyc(SEL_SETUP_CYC);
            state <= S_SEL;
          end
        end
        S_SEL: begin
          if (timer == '0) begin
            bit_cnt <= 4'h8;
            phase <= 1'b0;
            state <= S_ADDR;
          end
        end
        S_ADDR, S_DATA: begin
          if (sleep_request_low_abort_i) begin
            // raising select drops the whole transaction  [R05]
            pins.select_bar <= 1'b1;
            pins.sclk <= 1'b1;
            timer <= cyc(WRITE_GAP_CYC); // [R06]
            state <= S_GAP;
          end else if (timer == '0) begin
            timer <= cyc(HALF_CYC);
            if (!phase) begin
              // falling edge: present next bit msb first  [R23]
              pins.sclk <= 1'b0;
              pins.mosi <= shift[7];
              phase <= 1'b1;
            end else begin
              // rising edge: sensor samples mosi here  [R10]
              pins.sclk <= 1'b1;
              phase <= 1'b0;
              // read data stable since last fall  [R12] [R13]
              shift <= {shift[6:0], miso_val};
              bit_cnt <= bit_cnt - 4'h1;
              if (bit_cnt == 4'h1) begin
                if (state == S_ADDR) begin
                  if (cmd.write) begin
                    shift <= cmd.data;
                    // earlier write end must be 50 us before ours
                    timer <= cyc(HALF_CYC);
                    state <= S_WAIT;
                  end else begin
                    timer <= rad_wait(cmd.addr); // [R17]
                    state <= S_WAIT;
                  end
                end else begin
                  if (!cmd.write) begin
                    rd_data_o <= {shift[6:0], miso_val}; // [R22]
                    rd_valid_o <= 1'b1;
                  end
                  last_write <= cmd.write;
                  timer <= cyc(HALF_CYC);
                  state <= S_DESEL;
                end
              end
            end
          end
        end
        S_WAIT: begin
          if (timer == '0) begin
            bit_cnt <= 4'h8;
            phase <= 1'b0;
            state <= S_DATA;
          end
        end
        S_DESEL: begin
          if (timer == '0) begin
            // select raised after every command, burst or not  [R08]
            pins.select_bar <= 1'b1;
            // a burst write still owes the full write gap
            if (last_write) begin
              timer <= cyc(WRITE_GAP_CYC); // [R14] [R15]
            end else if (cmd.burst) begin
              timer <= cyc(BEXIT_CYC); // [R21]
            end else begin
              timer <= cyc(READ_GAP_CYC); // [R16]
            end
            state <= S_GAP;
          end
        end
        S_GAP: begin
          pins.select_bar <= 1'b1;
          pins.sclk <= 1'b1;
          if (timer == '0) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  int unsigned gap_cnt;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gap_cnt <= 0;
    end else if (state == S_GAP) begin
      gap_cnt <= gap_cnt + 1;
    end else begin
      gap_cnt <= 0;
    end
  end

  sel_frame_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state == S_IDLE |-> select_bar_o) // [R07]
    else $error("select low while idle");
  sel_before_clk_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    $fell(sclk_o) |-> !select_bar_o) // [R04]
    else $error("clock moved without select");
  start_by_req_a: assert property (@(posedge sys_clk_i)
    disable iff (!reset_n_i)
    $fell(select_bar_o) |-> $past(cmd_valid_i) && $past(cmd_ready_o)) // [R01]
    else $error("transfer started without request");
  abort_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == S_DATA && sleep_request_low_abort_i) |=> select_bar_o) // [R05]
    else $error("abort did not raise select");
  gap_min_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == S_GAP && $past(state) == S_GAP && timer == '0)
      |-> gap_cnt >= READ_GAP_CYC) // [R16]
    else $error("gap shorter than required");
  pause_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state == S_WAIT && !cmd.write) |-> sclk_o) // [R17]
    else $error("clock moved during address pause");
  idle_clk_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    select_bar_o && state != S_DESEL |-> sclk_o) // [R03]
    else $error("clock toggled while deselected");
  sleep_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    sleep_request_low_o) // [R02]
    else $error("sensor put to sleep by port");
  rd_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    rd_valid_o |=> !rd_valid_o ##1 state == S_DESEL || state == S_GAP) // [R11]
    else $error("read strobe malformed");

  write_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state == S_DESEL && cmd.write);
  read_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    rd_valid_o);
  abort_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state == S_DATA && sleep_request_low_abort_i);
  burst_c: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state == S_DESEL && cmd.burst);

endmodule // sensor_link_master

/* File: core/sensor_link_pkg.sv */
// constants and carrier types for the host-side serial master of the sensor
// assumes a 200 MHz system clock
package sensor_link_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  // serial clock half period; the 64-cycle timer holds each level 65 cycles, 325 ns high and low
  localparam int unsigned HALF_NS = 320;
  localparam int unsigned HALF_CYC = (HALF_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned WRITE_TO_WRITE_GAP_US = 50;
  localparam int unsigned WRITE_GAP_CYC = WRITE_TO_WRITE_GAP_US * CLK_MHZ;
  localparam int unsigned READ_ADDRESS_TO_DATA_GAP_US = 50;
  localparam int unsigned RAD_CYC = READ_ADDRESS_TO_DATA_GAP_US * CLK_MHZ;
  localparam int unsigned MOTION_GAP_US = 75;
  localparam int unsigned RAD_MOT_CYC = MOTION_GAP_US * CLK_MHZ;
  localparam int unsigned READ_GAP_NS = 250;
  localparam int unsigned READ_GAP_CYC =
    (READ_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned BURST_EXIT_HIGH_TIME_US = 4;
  localparam int unsigned BEXIT_CYC = BURST_EXIT_HIGH_TIME_US * CLK_MHZ;
  localparam int unsigned SEL_SETUP_NS = 120;
  localparam int unsigned SEL_SETUP_CYC =
    (SEL_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [6:0] MOTION_ADDR = 7'h02;
  localparam logic [6:0] MOTION_BURST_ADDR = 7'h50;
  localparam int unsigned DIR_BIT = 7;
  localparam logic [7:0] RESET_DATA = 8'h00;

  typedef struct packed {
    logic write;
    logic burst;
    logic [6:0] addr;
    logic [7:0] data;
  } cmd_t;

  typedef struct packed {
    logic sclk;
    logic mosi;
    logic select_bar;
  } pins_t;
endpackage

/* File: tb/sensor_port_model.sv */
// behavioural model of the sensor serial port with a small register file
// assumes the master drives sclk, mosi and select; miso is push-pull
`timescale 1ns/1ps
module sensor_port_model
  import sensor_link_pkg::*;
#(
  parameter int unsigned ASSIGNED_TOP = 64
)
(
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic select_bar_i,
  input wire logic awake_i,
  output logic miso_o,
  output logic [7:0] fault_o
);
  logic [7:0] regs [0:127];
  logic [7:0] shin, shout;
  logic [6:0] addr;
  logic wr;
  int nbit;
  realtime t_addr, t_wend, t_rend;
  initial begin
    for (int i = 0; i < 128; i++) regs[i] = 8'h00;
    regs[2] = 8'h81;
    fault_o = 8'h00;
    miso_o = 1'b0;
    nbit = 0;
    t_wend = -1.0e9;
    t_rend = -1.0e9;
  end
  ////////////////////////////////////////
  // select high drops the whole transaction and toggles miso
  always @(posedge select_bar_i) begin
    nbit = 0;
    miso_o = ~miso_o;
  end
  // only master clocks with select low and awake count
  always @(posedge sclk_i) begin
    if (!select_bar_i && awake_i) begin
      shin = {shin[6:0], mosi_i};
      nbit++;
      if (nbit == 8) begin
        wr = shin[7];
        addr = shin[6:0];
        t_addr = $realtime;
        shout = (addr < ASSIGNED_TOP) ? regs[addr] : 8'h00;
        if (!wr && $realtime - t_wend < 50000.0) fault_o++;
      end
      if (nbit == 16 && !wr) t_rend = $realtime;
      if (nbit == 16 && wr) begin
        if ($realtime - t_wend < 50000.0) fault_o++;
        t_wend = $realtime;
        if (addr < ASSIGNED_TOP) regs[addr] = shin;
      end
    end
  end
  // data launched on falls, held until the next fall
  always @(negedge sclk_i) begin
    if (!select_bar_i && nbit == 0 && $realtime - t_rend < 250.0)
      fault_o++;
    if (!select_bar_i && awake_i && !wr && nbit >= 8 && nbit < 16) begin
      if (nbit == 8 && $realtime - t_addr <
          ((addr == MOTION_ADDR || addr == MOTION_BURST_ADDR) ?
           75000.0 : 50000.0)) fault_o++;
      miso_o = shout[7];
      shout = {shout[6:0], 1'b0};
    end
  end
endmodule // sensor_port_model

/* File: tb/sensor_serial_slave_port_tb_top.sv */
// self-checking bench for the sensor serial master against the port model
// assumes the package constants of sensor_link_pkg
`timescale 1ns/1ps
module sensor_serial_slave_port_tb_top;
  import sensor_link_pkg::*;
  logic sys_clk_i, reset_n_i, cmd_valid_i, abort;
  cmd_t cmd_i;
  logic cmd_ready_o, rd_valid_o, miso, sclk_o, mosi_o, select_bar_o, awake;
  logic [7:0] rd_data_o, fault, q;
  int err_total, n_tests;
  logic burst_flag;
  sensor_link_master sensor_link_master_i (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .cmd_i(cmd_i), .cmd_valid_i(cmd_valid_i),
    .cmd_ready_o(cmd_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .miso_i(miso), .sclk_o(sclk_o),
    .sclk_oe_n_o(), .mosi_o(mosi_o), .mosi_oe_n_o(),
    .select_bar_o(select_bar_o), .select_bar_oe_n_o(),
    .sleep_request_low_abort_i(abort), .sleep_request_low_o(awake));
  sensor_port_model sensor_port_model_i (.sclk_i(sclk_o), .mosi_i(mosi_o),
    .select_bar_i(select_bar_o), .awake_i(awake), .miso_o(miso),
    .fault_o(fault));
  ////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 20000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check({15'h0, select_bar_o}, 16'h0001);
  endtask
  task automatic do_cmd(input logic wr, input logic [6:0] a,
                        input logic [7:0] d, output logic [7:0] rq);
    logic [15:0] sh;
    int n;
    wait_ready();
    cmd_i = {wr, burst_flag, a, d};
    cmd_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge sclk_o);
      sh = {sh[14:0], mosi_o};
    end
    check({8'h00, sh[15:8]}, {8'h00, wr, a});
    if (wr) check({8'h00, sh[7:0]}, {8'h00, d});
    rq = 8'h00;
    if (!wr) begin
      // the strobe rises with the last serial clock rise; look off that edge
      #1;
      n = 0;
      while (rd_valid_o !== 1'b1 && n < 50) begin
        @(posedge sys_clk_i);
        #1;
        n++;
      end
      check({15'h0, rd_valid_o}, 16'h0001);
      rq = rd_data_o;
    end
  endtask
  ////////////////////////////////////////
  task automatic t_readback;
    do_cmd(1'b1, 7'h10, 8'h5a, q);
    do_cmd(1'b0, 7'h10, 8'h00, q);
    check({8'h00, q}, 16'h005a);
  endtask
  task automatic t_unassigned;
    do_cmd(1'b0, 7'h45, 8'h00, q);
    check({8'h00, q}, 16'h0000);
  endtask
  task automatic t_motion;
    do_cmd(1'b0, MOTION_ADDR, 8'h00, q);
    check({8'h00, q}, 16'h0081);
  endtask
  task automatic t_burst;
    int n;
    burst_flag = 1'b1;
    do_cmd(1'b0, 7'h10, 8'h00, q);
    burst_flag = 1'b0;
    check({8'h00, q}, 16'h005a);
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 2000) begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    check({15'h0, n > int'(BEXIT_CYC) && n < 2000}, 16'h0001);
  endtask
  task automatic t_abort;
    wait_ready();
    cmd_i = {1'b1, 1'b0, 7'h11, 8'hcc};
    cmd_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    repeat (10) @(posedge sclk_o);
    #1;
    abort = 1'b1;
    repeat (200) @(posedge sys_clk_i);
    check({15'h0, select_bar_o}, 16'h0001);
    #1;
    abort = 1'b0;
    do_cmd(1'b0, 7'h11, 8'h00, q);
    check({8'h00, q}, 16'h0000);
  endtask
  ////////////////////////////////////////
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    #490000;
    err_total++;
    print_verdict();
  end
  initial begin
    err_total = 0;
    n_tests = 0;
    reset_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    abort = 1'b0;
    burst_flag = 1'b0;
    cmd_i = '0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    reset_n_i = 1'b1;
    check({15'h0, awake}, 16'h0001);
    t_readback();
    t_unassigned();
    t_motion();
    t_burst();
    t_abort();
    check({8'h00, fault}, 16'h0000);
    print_verdict();
  end
endmodule // sensor_serial_slave_port_tb_top
